/* verilog/ptr_device.sv */
// Pressure threshold register block: register map, reference capture, threshold events
// Notes on behaviour
// - Registers are 8-bit, selected by 7-bit address
// - Host never writes reserved address ranges
// - Host never touches unlisted addresses
// - Calibration reloads at power-up; host leaves it
// - Threshold interrupt enable gates event generation
// - Latch bit holds requests in event source
// - Low enable flags pressure below negative threshold
// - High enable flags pressure above threshold
// - Enabling interrupt needs high or low enable and threshold
// - Capture modes compare measured minus reference
// - Zero capture stores reference, subtracts it everywhere
// - Zero capture bit clears after next conversion
// - Zero clear restores normal, clears reference
// - Offset mode stores reference, result minus trim*256
// - Offset mode bit self-clears; clear restores normal
// - Threshold is unsigned 16-bit, hPa times 16
// - Threshold low byte below high byte address
//
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module ptr_device
  import ptr_pkg::*;
#(
  parameter logic [7:0] IDENT = 8'h5a  // Arbitrary identity value
) (
  input  wire logic        mclk_in,
  input  wire logic        rst_n_in,
  ptr_link_if.device       link,
  input  wire logic        conv_done_in,
  input  wire logic [23:0] meas_pressure_in,
  input  wire logic [15:0] meas_temp_in,
  input  wire logic [15:0] calib_in,
  output logic             boot_done_out,
  output logic [23:0]      pressure_result_out
);
  // ****************************************
  // Link decode
  // ****************************************
  logic        acc, wr, rd;
  assign acc = link.req & ~link.ack;
  assign wr  = acc & link.we & addr_writable(link.addr);
  assign rd  = acc & ~link.we;
  logic [7:0]  evt_cfg;
  logic [15:0] pressure_threshold;
  logic [15:0] pressure_offset_trim;
  logic [23:0] ref_p;
  logic [7:0]  ctrl1;
  logic [7:0]  ctrl2;
  logic [7:0]  ctrl3;
  logic [7:0]  qcfg;
  logic [7:0]  rescfg;
  logic [2:0]  event_src;
  logic [1:0]  status;
  logic [15:0] temp_q;
  logic [15:0] calib;
  logic        zero_active;
  logic        ripf_active;
  // ****************************************
  // Boot load of calibration
  // ****************************************
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      boot_done_out <= 1'b0;
      calib         <= '0;
    end else if (!boot_done_out) begin
      calib         <= calib_in;
      boot_done_out <= 1'b1;
    end
  end
  logic conv;
  assign conv = conv_done_in & boot_done_out;
  // ****************************************
  // Pressure arithmetic
  // ****************************************
  logic [23:0] meas;
  logic [23:0] next_ref;
  logic [23:0] next_result;
  logic [23:0] diff;
  logic [24:0] ths_counts;
  logic        hi_evt;
  logic        lo_evt;
  logic        cap_zero;
  logic        cap_ripf;

  assign meas     = meas_pressure_in + {{8{calib[15]}}, calib};
  assign cap_zero = conv & evt_cfg[B_ZO_CAPTURE];
  assign cap_ripf = conv & evt_cfg[B_RCO_MODE];
  assign next_ref = (cap_zero | cap_ripf) ? meas : ref_p;
  always_comb begin
    if (zero_active | cap_zero) begin
      next_result = meas - next_ref;
    end else if (ripf_active | cap_ripf) begin
      next_result = meas - {pressure_offset_trim, {TRIM_SHIFT{1'b0}}};
    end else begin
      next_result = meas;
    end
  end
  assign diff       = (zero_active | cap_zero | ripf_active | cap_ripf) ? meas - next_ref : meas;
  assign ths_counts = {1'b0, pressure_threshold, {THS_SHIFT{1'b0}}};
  assign hi_evt     = evt_cfg[B_HIGH_EN] &
                      ($signed({diff[23], diff}) > $signed(ths_counts));
  assign lo_evt     = evt_cfg[B_LOW_EN] &
                      ($signed({diff[23], diff}) < -$signed(ths_counts));
  // ****************************************
  // Event configuration and capture modes
  // ****************************************
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      evt_cfg     <= RST_ZERO;
      zero_active <= 1'b0;
      ripf_active <= 1'b0;
    end else begin
      if (wr && link.addr == A_EVT_CFG) begin
        evt_cfg <= link.wdata & ~(8'(1) << B_ZO_CLEAR) & ~(8'(1) << B_RCO_CLEAR);
      end else begin
        if (cap_zero) begin
          evt_cfg[B_ZO_CAPTURE] <= 1'b0;
        end
        if (cap_ripf) begin
          evt_cfg[B_RCO_MODE] <= 1'b0;
        end
      end
      if (cap_zero) begin
        zero_active <= 1'b1;
      end
      if (cap_ripf) begin
        ripf_active <= 1'b1;
      end
      if (wr && link.addr == A_EVT_CFG && link.wdata[B_ZO_CLEAR]) begin
        zero_active <= 1'b0;
      end
      if (wr && link.addr == A_EVT_CFG && link.wdata[B_RCO_CLEAR]) begin
        ripf_active <= 1'b0;
      end
    end
  end
  // ****************************************
  // Reference register
  // ****************************************
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ref_p <= '0;
    end else if (wr && link.addr == A_EVT_CFG && link.wdata[B_ZO_CLEAR]) begin
      ref_p <= '0;
    end else if (cap_zero | cap_ripf) begin
      ref_p <= next_ref;
    end else if (wr && link.addr == A_REF_LO) begin
      ref_p[7:0] <= link.wdata;
    end else if (wr && link.addr == A_REF_MID) begin
      ref_p[15:8] <= link.wdata;
    end else if (wr && link.addr == A_REF_HI) begin
      ref_p[23:16] <= link.wdata;
    end
  end
  // ****************************************
  // Plain read/write registers
  // ****************************************
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pressure_threshold   <= '0;
      pressure_offset_trim <= '0;
      ctrl1                <= RST_ZERO;
      ctrl2                <= RST_CTRL2;
      ctrl3                <= RST_ZERO;
      qcfg                 <= RST_ZERO;
      rescfg               <= RST_ZERO;
    end else if (wr) begin
      unique case (link.addr)
        A_THS_LO:  pressure_threshold[7:0]    <= link.wdata;
        A_THS_HI:  pressure_threshold[15:8]   <= link.wdata;
        A_TRIM_LO: pressure_offset_trim[7:0]  <= link.wdata;
        A_TRIM_HI: pressure_offset_trim[15:8] <= link.wdata;
        A_CTRL1:   ctrl1                      <= link.wdata;
        A_CTRL2:   ctrl2                      <= link.wdata;
        A_CTRL3:   ctrl3                      <= link.wdata;
        A_QCFG:    qcfg                       <= link.wdata;
        A_RESCFG:  rescfg                     <= link.wdata;
        default:   ;
      endcase
    end
  end
  // ****************************************
  // Results and event source
  // ****************************************
  logic src_clr;
  assign src_clr = rd && link.addr == A_EVT_SRC;
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pressure_result_out <= '0;
      temp_q              <= '0;
    end else if (conv) begin
      pressure_result_out <= next_result;
      temp_q              <= meas_temp_in;
    end
  end
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      event_src <= '0;
    end else if (conv && evt_cfg[B_IRQ_EN]) begin
      if (evt_cfg[B_LATCH]) begin
        event_src[E_HIGH] <= event_src[E_HIGH] | hi_evt;
        event_src[E_LOW]  <= event_src[E_LOW] | lo_evt;
      end else begin
        event_src[E_HIGH] <= hi_evt;
        event_src[E_LOW]  <= lo_evt;
      end
    end else if (src_clr && evt_cfg[B_LATCH]) begin
      event_src <= '0;
    end else if (!evt_cfg[B_IRQ_EN]) begin
      event_src <= '0;
    end
  end
  assign link.event_irq = evt_cfg[B_IRQ_EN] & (event_src[E_HIGH] | event_src[E_LOW]);
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      status <= '0;
    end else if (conv) begin
      status <= 2'b11;
    end else begin
      if (rd && link.addr == A_PRES_HI) begin
        status[S_P_NEW] <= 1'b0;
      end
      if (rd && link.addr == A_TEMP_HI) begin
        status[S_T_NEW] <= 1'b0;
      end
    end
  end
  // ****************************************
  // Read answer
  // ****************************************
  logic [7:0] rmux;
  always_comb begin
    unique case (link.addr)
      A_EVT_CFG:  rmux = evt_cfg;
      A_THS_LO:   rmux = pressure_threshold[7:0];
      A_THS_HI:   rmux = pressure_threshold[15:8];
      A_IDENT:    rmux = IDENT;
      A_CTRL1:    rmux = ctrl1;
      A_CTRL2:    rmux = ctrl2;
      A_CTRL3:    rmux = ctrl3;
      A_QCFG:     rmux = qcfg;
      A_REF_LO:   rmux = ref_p[7:0];
      A_REF_MID:  rmux = ref_p[15:8];
      A_REF_HI:   rmux = ref_p[23:16];
      A_TRIM_LO:  rmux = pressure_offset_trim[7:0];
      A_TRIM_HI:  rmux = pressure_offset_trim[15:8];
      A_RESCFG:   rmux = rescfg;
      A_EVT_SRC:  rmux = {5'h00, link.event_irq, event_src[E_LOW], event_src[E_HIGH]};
      A_STATUS:   rmux = {6'h00, status};
      A_PRES_LO:  rmux = pressure_result_out[7:0];
      A_PRES_MID: rmux = pressure_result_out[15:8];
      A_PRES_HI:  rmux = pressure_result_out[23:16];
      A_TEMP_LO:  rmux = temp_q[7:0];
      A_TEMP_HI:  rmux = temp_q[15:8];
      default:    rmux = RST_ZERO;
    endcase
  end
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      link.ack   <= 1'b0;
      link.rdata <= '0;
    end else begin
      link.ack <= acc;
      if (rd) begin
        link.rdata <= rmux;
      end
    end
  end

endmodule // ptr_device
`default_nettype wire

/* verilog/ptr_pkg.sv */
// Shared constants for the pressure threshold register block and its host
package ptr_pkg;

  // ****************************************
  // Register addresses
  // ****************************************
  localparam int           AW              = 7;
  localparam logic [6:0]   A_EVT_CFG       = 7'h0b;
  localparam logic [6:0]   A_THS_LO        = 7'h0c;
  localparam logic [6:0]   A_THS_HI        = 7'h0d;
  localparam logic [6:0]   A_IDENT         = 7'h0f;
  localparam logic [6:0]   A_CTRL1         = 7'h10;
  localparam logic [6:0]   A_CTRL2         = 7'h11;
  localparam logic [6:0]   A_CTRL3         = 7'h12;
  localparam logic [6:0]   A_QCFG          = 7'h14;
  localparam logic [6:0]   A_REF_LO        = 7'h15;
  localparam logic [6:0]   A_REF_MID       = 7'h16;
  localparam logic [6:0]   A_REF_HI        = 7'h17;
  localparam logic [6:0]   A_TRIM_LO       = 7'h18;
  localparam logic [6:0]   A_TRIM_HI       = 7'h19;
  localparam logic [6:0]   A_RESCFG        = 7'h1a;
  localparam logic [6:0]   A_EVT_SRC       = 7'h25;
  localparam logic [6:0]   A_QSTATE        = 7'h26;
  localparam logic [6:0]   A_STATUS        = 7'h27;
  localparam logic [6:0]   A_PRES_LO       = 7'h28;
  localparam logic [6:0]   A_PRES_MID      = 7'h29;
  localparam logic [6:0]   A_PRES_HI       = 7'h2a;
  localparam logic [6:0]   A_TEMP_LO       = 7'h2b;
  localparam logic [6:0]   A_TEMP_HI       = 7'h2c;
  localparam logic [6:0]   A_FILT_CLR      = 7'h33;

  // ****************************************
  // Reset values and field positions
  // ****************************************
  localparam logic [7:0]   RST_ZERO        = 8'h00;
  localparam logic [7:0]   RST_CTRL2       = 8'h10;
  localparam int           B_RCO_MODE      = 7;
  localparam int           B_RCO_CLEAR     = 6;
  localparam int           B_ZO_CAPTURE    = 5;
  localparam int           B_ZO_CLEAR      = 4;
  localparam int           B_IRQ_EN        = 3;
  localparam int           B_LATCH         = 2;
  localparam int           B_LOW_EN        = 1;
  localparam int           B_HIGH_EN       = 0;
  localparam int           E_HIGH          = 0;
  localparam int           E_LOW           = 1;
  localparam int           E_ACTIVE        = 2;
  localparam int           S_P_NEW         = 0;
  localparam int           S_T_NEW         = 1;
  localparam int           TRIM_SHIFT      = 8;
  localparam int           THS_SHIFT       = 8;

  // ****************************************
  // Host register map
  // ****************************************
  localparam int           HAW             = 4;
  localparam logic [3:0]   H_CMD           = 4'h0;
  localparam logic [3:0]   H_RESULT        = 4'h4;
  localparam logic [3:0]   H_STAT          = 4'h8;
  localparam logic [3:0]   H_MASK          = 4'hc;
  localparam int           C_DATA_LSB      = 0;
  localparam int           C_ADDR_LSB      = 8;
  localparam int           C_WRITE         = 16;
  localparam int           R_BUSY          = 8;
  localparam int           SB_DONE         = 0;
  localparam int           SB_REFUSED      = 1;
  localparam int           SB_EVENT        = 2;
  localparam int           STAT_W          = 3;

  // ****************************************
  // Map membership
  // ****************************************
  function automatic logic addr_writable(input logic [6:0] a);
    return (a >= A_EVT_CFG && a <= A_THS_HI) || (a >= A_CTRL1 && a <= A_CTRL3) ||
           (a >= A_QCFG && a <= A_RESCFG);
  endfunction

  function automatic logic addr_listed(input logic [6:0] a);
    return addr_writable(a) || a == A_IDENT || (a >= A_EVT_SRC && a <= A_TEMP_HI) ||
           a == A_FILT_CLR;
  endfunction

endpackage

/* verilog/ptr_link_if.sv */
// Register access link between host controller and threshold register block
`timescale 1ns/100ps
`default_nettype none
interface ptr_link_if;
  logic       req;
  logic       we;
  logic [6:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       ack;
  logic       event_irq;

  modport device(input req, input we, input addr, input wdata,
                 output rdata, output ack, output event_irq);
  modport host(output req, output we, output addr, output wdata,
               input rdata, input ack, input event_irq);
endinterface
`default_nettype wire

/* verilog/ptr_host.sv */
// Host controller: AHB-Lite command registers driving the register link
`timescale 1ns/100ps
`default_nettype none
module ptr_host
  import ptr_pkg::*;
(
  input  wire logic        mclk_in,
  input  wire logic        rst_n_in,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic [31:0]      hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  output logic             irq_out,
  ptr_link_if.host         link
);

  // ****************************************
  // AHB-Lite slave
  // ****************************************
  logic           ph_valid;
  logic           ph_wr;
  logic [HAW-1:0] ph_addr;

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ph_valid <= 1'b0;
      ph_wr    <= 1'b0;
      ph_addr  <= '0;
    end else if (hready_in) begin
      ph_valid <= hsel_in & htrans_in[1];
      ph_wr    <= hwrite_in;
      ph_addr  <= haddr_in[HAW-1:0];
    end
  end

  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;

  logic                wr_cmd;
  logic                wr_stat;
  logic                wr_mask;
  logic [STAT_W-1:0]   stat;
  logic [STAT_W-1:0]   mask;
  logic [7:0]          result;
  logic                thr_set;
  logic                refuse;
  logic                ev_q;
  logic [6:0]          c_addr;
  logic [7:0]          c_data;
  logic                c_write;

  assign wr_cmd  = ph_valid & ph_wr & (ph_addr == H_CMD);
  assign wr_stat = ph_valid & ph_wr & (ph_addr == H_STAT);
  assign wr_mask = ph_valid & ph_wr & (ph_addr == H_MASK);
  assign c_addr  = hwdata_in[C_ADDR_LSB +: AW];
  assign c_data  = hwdata_in[C_DATA_LSB +: 8];
  assign c_write = hwdata_in[C_WRITE];

  // ****************************************
  // Command checks
  // ****************************************
  always_comb begin
    refuse = link.req;
    if (!addr_listed(c_addr)) begin
      refuse = 1'b1;
    end
    if (c_write && !addr_writable(c_addr)) begin
      refuse = 1'b1;
    end
    if (c_write && c_addr == A_EVT_CFG && c_data[B_IRQ_EN] &&
        (!(c_data[B_HIGH_EN] | c_data[B_LOW_EN]) || !thr_set)) begin
      refuse = 1'b1;
    end
  end

  // ****************************************
  // Link transfer
  // ****************************************
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      link.req   <= 1'b0;
      link.we    <= 1'b0;
      link.addr  <= '0;
      link.wdata <= '0;
      result     <= '0;
      thr_set    <= 1'b0;
    end else if (link.req) begin
      if (link.ack) begin
        link.req <= 1'b0;
        if (!link.we) begin
          result <= link.rdata;
        end
      end
    end else if (wr_cmd && !refuse) begin
      link.req   <= 1'b1;
      link.we    <= c_write;
      link.addr  <= c_addr;
      link.wdata <= c_data;
      if (c_write && (c_addr == A_THS_LO || c_addr == A_THS_HI)) begin
        thr_set <= 1'b1;
      end
    end
  end

  // ****************************************
  // Status, mask and interrupt
  // ****************************************
  logic [STAT_W-1:0] sets;
  always_comb begin
    sets              = '0;
    sets[SB_DONE]     = link.req & link.ack;
    sets[SB_REFUSED]  = wr_cmd & refuse;
    sets[SB_EVENT]    = link.event_irq & ~ev_q;
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stat <= '0;
      mask <= '0;
      ev_q <= 1'b0;
    end else begin
      ev_q <= link.event_irq;
      stat <= (stat & ~(wr_stat ? hwdata_in[STAT_W-1:0] : '0)) | sets;
      if (wr_mask) begin
        mask <= hwdata_in[STAT_W-1:0];
      end
    end
  end

  assign irq_out = |(stat & mask);

  always_comb begin
    hrdata_out = '0;
    unique case (ph_addr)
      H_RESULT: hrdata_out = {23'h000000, link.req, result};
      H_STAT:   hrdata_out = {29'h00000000, stat};
      H_MASK:   hrdata_out = {29'h00000000, mask};
      default:  hrdata_out = '0;
    endcase
  end

endmodule // ptr_host
`default_nettype wire

/* bench/ptr_assertions.sv */
// Link protocol and register checks for the threshold register block
`timescale 1ns/100ps
`default_nettype none
module ptr_assertions
  import ptr_pkg::*;
#(
  parameter logic [7:0] IDENT = 8'h5a
) (
  input wire logic       mclk_in,
  input wire logic       rst_n_in,
  input wire logic       req,
  input wire logic       we,
  input wire logic [6:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic       ack,
  input wire logic       event_irq
);
  // ****************************************
  // Shadow of written config and threshold
  // ****************************************
  logic [7:0] cfg;
  logic [7:0] ths_lo;
  logic       take;
  logic       rd_ack;
  assign take   = req && !ack && we;
  assign rd_ack = ack && !we;
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cfg    <= 8'h00;
      ths_lo <= 8'h00;
    end else if (take && addr == A_EVT_CFG) begin
      cfg <= wdata;
    end else if (take && addr == A_THS_LO) begin
      ths_lo <= wdata;
    end
  end
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_in);
  chk_ack_one_late: assert property (req && !ack |=> ack)
    else $error("ack not one cycle after request");
  chk_ack_pulse: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  chk_ack_in_req: assert property (ack |-> req)
    else $error("ack without request");
  chk_req_release: assert property (req && ack |=> !req)
    else $error("request not dropped after ack");
  chk_req_held: assert property (req && !ack |=> $stable(addr) && $stable(we) && $stable(wdata))
    else $error("request changed before ack");
  chk_ident_read: assert property (rd_ack && addr == A_IDENT |-> rdata == IDENT)
    else $error("identity read wrong");
  chk_ths_readback: assert property (rd_ack && addr == A_THS_LO |-> rdata == ths_lo)
    else $error("threshold low byte readback wrong");
  chk_cfg_readback: assert property (rd_ack && addr == A_EVT_CFG
    |-> rdata[3:0] == cfg[3:0] && !rdata[6] && !rdata[4])
    else $error("config readback wrong");
  chk_irq_gated: assert property (event_irq |-> cfg[B_IRQ_EN])
    else $error("event irq with enable clear");
endmodule // ptr_assertions
`default_nettype wire

/* bench/tb_pressure_threshold_regs.sv */
// Self-checking bench for the threshold register block and its host
`timescale 1ns/100ps
`default_nettype none
module tb_pressure_threshold_regs
  import ptr_pkg::*;
;
  localparam logic [7:0] ID_VAL = 8'h3c;  // Arbitrary identity value
  logic        mclk_in  = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        hsel     = 1'b0;
  logic [31:0] haddr    = 32'h0;
  logic [1:0]  htrans   = 2'b00;
  logic        hwrite   = 1'b0;
  logic [31:0] hwdata   = 32'h0;
  logic        conv     = 1'b0;
  logic [23:0] meas     = 24'h0;
  wire  [31:0] hrdata;
  wire         hready;
  wire         irq;
  wire         hresp;
  wire         boot;
  wire  [23:0] pres;
  int          errors    = 0;
  int          tests_run = 0;
  int          cycles    = 0;
  ptr_link_if lnk ();
  ptr_host u_ptr_host (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'b010),
    .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
    .hreadyout_out(hready), .hresp_out(hresp), .irq_out(irq), .link(lnk));
  ptr_device #(.IDENT(ID_VAL)) u_ptr_device (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .link(lnk), .conv_done_in(conv), .meas_pressure_in(meas),
    .meas_temp_in(meas[15:0]), .calib_in(16'h0010), .boot_done_out(boot),
    .pressure_result_out(pres));
  ptr_assertions #(.IDENT(ID_VAL)) u_ptr_assertions (.mclk_in(mclk_in),
    .rst_n_in(rst_n_in), .req(lnk.req), .we(lnk.we), .addr(lnk.addr),
    .wdata(lnk.wdata), .rdata(lnk.rdata), .ack(lnk.ack), .event_irq(lnk.event_irq));
  // ****************************************
  // Clock, timeout and shared tasks
  // ****************************************
  always #5 mclk_in = ~mclk_in;
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles > 8000) begin
      errors++;
      wrap_up();
    end
  end
  task wrap_up;
    if (errors == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task ahb(input logic w, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {28'h0, a};
    hwrite <= w;
    do @(posedge mclk_in); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge mclk_in); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  // One link access through the host; data checked on accepted reads
  task xf(input logic w, input logic [6:0] a, input logic [7:0] d,
          input logic [1:0] es, input logic [7:0] er);
    logic [31:0] sta;
    logic [31:0] r;
    ahb(1'b1, H_STAT, 32'h3, r);
    ahb(1'b1, H_CMD, {15'h0, w, 1'b0, a, d}, r);
    do ahb(1'b0, H_STAT, 32'h0, sta); while (sta[1:0] === 2'b00);
    ahb(1'b0, H_RESULT, 32'h0, r);
    check($sformatf("status of %h", a), {30'h0, es}, {30'h0, sta[1:0]});
    if (!w && es == 2'b01) check($sformatf("reg %h", a), {24'h0, er}, {24'h0, r[7:0]});
  endtask
  task cv(input logic [23:0] p);
    meas <= p;
    conv <= 1'b1;
    @(posedge mclk_in);
    conv <= 1'b0;
    @(posedge mclk_in);
  endtask
  task res(input logic [23:0] e);
    xf(1'b0, A_PRES_LO, 8'h00, 2'b01, e[7:0]);
    xf(1'b0, A_PRES_MID, 8'h00, 2'b01, e[15:8]);
    xf(1'b0, A_PRES_HI, 8'h00, 2'b01, e[23:16]);
    check("result out", {8'h0, e}, {8'h0, pres});
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin : main
    logic [6:0]  a;
    logic [31:0] r;
    repeat (10) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    repeat (2) @(posedge mclk_in);
    check("boot done", 32'h1, {31'h0, boot});
    check("bus response", 32'h0, {31'h0, hresp});
    for (int i = 11; i <= 26; i++) begin
      a = 7'(i);
      if (a == 7'h0e || a == 7'h13) xf(1'b0, a, 8'h00, 2'b10, 8'h00);
      else xf(1'b0, a, 8'h00, 2'b01, a == A_CTRL2 ? 8'h10 : a == A_IDENT ? ID_VAL : 8'h00);
    end
    xf(1'b1, 7'h05, 8'h11, 2'b10, 8'h00);
    xf(1'b1, 7'h1f, 8'h11, 2'b10, 8'h00);
    xf(1'b1, A_IDENT, 8'h00, 2'b10, 8'h00);
    xf(1'b1, A_EVT_CFG, 8'h09, 2'b10, 8'h00);
    xf(1'b1, A_THS_LO, 8'h10, 2'b01, 8'h00);
    xf(1'b1, A_THS_HI, 8'h00, 2'b01, 8'h00);
    xf(1'b0, A_THS_LO, 8'h00, 2'b01, 8'h10);
    xf(1'b1, A_EVT_CFG, 8'h08, 2'b10, 8'h00);
    cv(24'h001000);
    res(24'h001010);
    xf(1'b0, A_STATUS, 8'h00, 2'b01, 8'h02);
    xf(1'b0, A_TEMP_HI, 8'h00, 2'b01, 8'h10);
    xf(1'b1, A_EVT_CFG, 8'h09, 2'b01, 8'h00);
    cv(24'h002000);
    xf(1'b0, A_EVT_SRC, 8'h00, 2'b01, 8'h05);
    ahb(1'b0, H_STAT, 32'h0, r);
    check("event status", 32'h1, {31'h0, r[SB_EVENT]});
    @(posedge mclk_in);
    check("irq masked", 32'h0, {31'h0, irq});
    ahb(1'b1, H_MASK, 32'h4, r);
    @(posedge mclk_in);
    check("irq unmasked", 32'h1, {31'h0, irq});
    ahb(1'b1, H_STAT, 32'h4, r);
    @(posedge mclk_in);
    check("irq cleared", 32'h0, {31'h0, irq});
    xf(1'b1, A_EVT_CFG, 8'h2b, 2'b01, 8'h00);
    cv(24'h100000);
    res(24'h000000);
    xf(1'b0, A_REF_LO, 8'h00, 2'b01, 8'h10);
    xf(1'b0, A_REF_HI, 8'h00, 2'b01, 8'h10);
    xf(1'b0, A_EVT_CFG, 8'h00, 2'b01, 8'h0b);
    xf(1'b0, A_EVT_SRC, 8'h00, 2'b01, 8'h00);
    cv(24'h101400);
    res(24'h001400);
    xf(1'b0, A_EVT_SRC, 8'h00, 2'b01, 8'h05);
    cv(24'h0fec00);
    res(24'hffec00);
    xf(1'b0, A_EVT_SRC, 8'h00, 2'b01, 8'h06);
    xf(1'b1, A_EVT_CFG, 8'h0f, 2'b01, 8'h00);
    cv(24'h101400);
    cv(24'h100000);
    xf(1'b0, A_EVT_SRC, 8'h00, 2'b01, 8'h07);
    xf(1'b0, A_EVT_SRC, 8'h00, 2'b01, 8'h00);
    xf(1'b1, A_EVT_CFG, 8'h10, 2'b01, 8'h00);
    xf(1'b0, A_REF_HI, 8'h00, 2'b01, 8'h00);
    cv(24'h002000);
    res(24'h002010);
    xf(1'b0, A_EVT_SRC, 8'h00, 2'b01, 8'h00);
    check("device irq", 32'h0, {31'h0, lnk.event_irq});
    xf(1'b1, A_TRIM_LO, 8'h02, 2'b01, 8'h00);
    xf(1'b1, A_EVT_CFG, 8'h80, 2'b01, 8'h00);
    cv(24'h003000);
    res(24'h002e10);
    xf(1'b0, A_REF_MID, 8'h00, 2'b01, 8'h30);
    xf(1'b0, A_EVT_CFG, 8'h00, 2'b01, 8'h00);
    xf(1'b1, A_EVT_CFG, 8'h40, 2'b01, 8'h00);
    cv(24'h003000);
    res(24'h003010);
    wrap_up();
  end
endmodule // tb_pressure_threshold_regs
`default_nettype wire
